// *** core/irq_col_rssi_pkg.sv ***
// Functional notes
// - Five source enables set, no-response clear after reset
// - Position bits nine, eight in enable register
// - Low eight position bits at 0x0E
// - Position register zero on reset, low byte zero with enable low
// - Position low byte clears after host read of 0x0E
// - Other protocols load error bit position
// - Oscillator stable flag after about 200 us
// - Aux strength B5-B3, main B2-B0, B7 zero
// - Swap option selects primary input for aux
// - Peak strength latched, held until transmit
// - Transmit start clears both strength values
// - Three-bit strength codes, seven steps
// - Amplitude command reports field while transmitter off
// - Status read clears flags and request line
// - Collision at seven pulses, six by option
package irq_col_rssi_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h0d;
    localparam logic [4:0] ADDR_COL_LOW = 5'h0e;
    localparam logic [4:0] ADDR_STRENGTH = 5'h0f;

    localparam logic [5:0] ENABLE_RESET = 6'h3e;
    localparam logic [7:0] COL_LOW_RESET = 8'h00;

    // Enable field positions
    localparam int EN_FIFO = 5;
    localparam int EN_CRC = 4;
    localparam int EN_PARITY = 3;
    localparam int EN_FRAMING = 2;
    localparam int EN_COLLISION = 1;
    localparam int EN_NORESP = 0;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLOCK_HZ = 50000000;
    localparam int OSC_SETTLE_US = 200;
    localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_US * (CLOCK_HZ / 1000000));

    localparam logic [2:0] COL_PULSES_DEFAULT = 3'h7;
    localparam logic [2:0] COL_PULSES_OPTION = 3'h6;

    // Register access from the host port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    // Receive-side events from the decoder
    typedef struct packed {
        logic tx_start;
        logic rx_active;
        logic amp_measure;
        logic [2:0] env_primary;
        logic [2:0] env_secondary;
        logic [2:0] rf_amplitude;
        logic err_valid;
        logic [9:0] err_pos;
        logic sub_pulse;
        logic bit_boundary;
        logic type_a_106k;
    } rx_event_s;

    typedef struct packed {
        logic fifo;
        logic crc;
        logic parity;
        logic framing;
        logic collision;
        logic noresp;
    } irq_src_s;

endpackage

// *** core/irq_col_rssi_regs.sv ***
`timescale 1ns/10ps
module irq_col_rssi_regs #(
    parameter int OSC_CYCLES = irq_col_rssi_pkg::OSC_SETTLE_CYCLES
) (
    input wire logic CLOCK, // Device clock
    input wire logic RESET, // Power-on reset, active high
    input wire logic ENABLE, // Enable pin, low clears position low byte, status and request
    input wire irq_col_rssi_pkg::host_req_s HOST_REQ, // Host access
    input wire irq_col_rssi_pkg::rx_event_s RX_EVT, // Receiver events
    input wire irq_col_rssi_pkg::irq_src_s IRQ_SRC, // Interrupt sources
    input wire logic SWAP_INPUTS, // Chip status control option B3
    input wire logic COL_SIX_PULSES, // Special function option B0
    output logic [7:0] RDATA, // Read data, one cycle after read
    output logic IRQ // Interrupt request line
);
    import irq_col_rssi_pkg::*;

    typedef struct packed {
        logic [5:0] enable;
        logic [9:0] col_pos;
        logic osc_ok;
        logic [31:0] osc_cnt;
        logic [2:0] aux_strength;
        logic [2:0] main_strength;
        logic [5:0] status;
        logic [2:0] pulse_cnt;
        logic [9:0] bit_idx;
        logic [7:0] rdata;
        logic irq;
    } state_s;

    state_s state_r;
    state_s state_nxt;

    logic [2:0] aux_in;
    logic [2:0] main_in;
    logic [2:0] pulse_limit;
    logic col_hit;
    logic [5:0] set_vec;

    always_comb begin
        state_nxt = state_r;
        // ****************************************
        // Strength channel selection
        // ****************************************
        if (RX_EVT.amp_measure) begin
            aux_in = RX_EVT.rf_amplitude;
            main_in = RX_EVT.rf_amplitude;
        end else if (SWAP_INPUTS) begin
            aux_in = RX_EVT.env_primary;
            main_in = RX_EVT.env_secondary;
        end else begin
            aux_in = RX_EVT.env_secondary;
            main_in = RX_EVT.env_primary;
        end
        // ****************************************
        // Collision detection at 106 kbps
        // ****************************************
        pulse_limit = COL_SIX_PULSES ? COL_PULSES_OPTION
                                     : COL_PULSES_DEFAULT;
        col_hit = 1'b0;
        if (RX_EVT.bit_boundary) begin
            state_nxt.pulse_cnt = 3'h0;
            state_nxt.bit_idx = state_r.bit_idx + 10'h001;
        end else if (RX_EVT.sub_pulse && RX_EVT.rx_active) begin
            if (state_r.pulse_cnt != 3'h7) begin
                state_nxt.pulse_cnt = state_r.pulse_cnt + 3'h1;
            end
            // Hit fires once, on the pulse that reaches the limit
            col_hit = RX_EVT.type_a_106k &&
                      (state_r.pulse_cnt + 3'h1 == pulse_limit);
        end
        if (RX_EVT.tx_start) begin
            state_nxt.bit_idx = 10'h000;
            state_nxt.pulse_cnt = 3'h0;
            state_nxt.aux_strength = 3'h0;
            state_nxt.main_strength = 3'h0;
        end else if (RX_EVT.rx_active || RX_EVT.amp_measure) begin
            // Peak hold keeps the value readable after the packet
            if (aux_in > state_r.aux_strength) begin
                state_nxt.aux_strength = aux_in;
            end
            if (main_in > state_r.main_strength) begin
                state_nxt.main_strength = main_in;
            end
        end
        // ****************************************
        // Oscillator settle timer
        // ****************************************
        if (!state_r.osc_ok) begin
            if (state_r.osc_cnt >= 32'(OSC_CYCLES - 1)) begin
                state_nxt.osc_ok = 1'b1;
            end else begin
                state_nxt.osc_cnt = state_r.osc_cnt + 32'h1;
            end
        end
        // ****************************************
        // Host access
        // ****************************************
        state_nxt.rdata = 8'h00;
        if (HOST_REQ.wr && HOST_REQ.addr == ADDR_IRQ_ENABLE) begin
            state_nxt.enable = HOST_REQ.wdata[5:0];
        end
        if (HOST_REQ.rd) begin
            case (HOST_REQ.addr)
                ADDR_IRQ_STATUS: begin
                    state_nxt.rdata = {2'h0, state_r.status};
                    state_nxt.status = 6'h00;
                end
                ADDR_IRQ_ENABLE: begin
                    state_nxt.rdata = {state_r.col_pos[9:8],
                                       state_r.enable};
                end
                ADDR_COL_LOW: begin
                    state_nxt.rdata = state_r.col_pos[7:0];
                    state_nxt.col_pos[7:0] = COL_LOW_RESET;
                end
                ADDR_STRENGTH: begin
                    state_nxt.rdata = {1'b0, state_r.osc_ok,
                                       state_r.aux_strength,
                                       state_r.main_strength};
                end
                default: begin
                    state_nxt.rdata = 8'h00;
                end
            endcase
        end
        // Events land after the read-clear so a same-cycle event survives
        if (col_hit) begin
            state_nxt.col_pos = state_r.bit_idx;
        end else if (RX_EVT.err_valid && !RX_EVT.type_a_106k) begin
            state_nxt.col_pos = RX_EVT.err_pos;
        end
        set_vec = {IRQ_SRC.fifo, IRQ_SRC.crc, IRQ_SRC.parity,
                   IRQ_SRC.framing, IRQ_SRC.collision | col_hit,
                   IRQ_SRC.noresp};
        state_nxt.status = state_nxt.status | set_vec;
        // Only enabled sources drive the line
        state_nxt.irq = |(state_nxt.status & state_r.enable);
        if (!ENABLE) begin
            state_nxt.col_pos[7:0] = COL_LOW_RESET;
            state_nxt.status = 6'h00;
            state_nxt.irq = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state_r <= '0;
            state_r.enable <= ENABLE_RESET;
            state_r.col_pos <= 10'h000;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign RDATA = state_r.rdata;
    assign IRQ = state_r.irq;

endmodule

// *** test/irq_col_rssi_regs_assertions.sv ***
`timescale 1ns/10ps
module irq_col_rssi_chk #(
    parameter int OSC_CYCLES = 20
) (
    input wire logic CLOCK, // Device clock
    input wire logic RESET, // Power-on reset
    input wire logic ENABLE, // Enable pin
    input wire irq_col_rssi_pkg::host_req_s HOST_REQ, // Host access
    input wire irq_col_rssi_pkg::rx_event_s RX_EVT, // Receiver events
    input wire irq_col_rssi_pkg::irq_src_s IRQ_SRC, // Interrupt sources
    input wire logic [7:0] RDATA, // Read data
    input wire logic IRQ // Interrupt request
);
    import irq_col_rssi_pkg::*;
    int cnt;
    logic cause;
    // Enable writes may expose a pending flag, so they count as a cause
    assign cause = (|IRQ_SRC) || HOST_REQ.wr;
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET)
            cnt <= 0;
        else if (cnt < OSC_CYCLES + 4)
            cnt <= cnt + 1;
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    sequence s_col_rd;
        HOST_REQ.rd && HOST_REQ.addr == ADDR_COL_LOW && !RX_EVT.err_valid
            && !RX_EVT.sub_pulse;
    endsequence
    sequence s_str_rd;
        HOST_REQ.rd && HOST_REQ.addr == ADDR_STRENGTH;
    endsequence
    chk_rdata_idle: assert property (!HOST_REQ.rd |=> RDATA == 8'h00)
        else $error("read data not zero while idle");
    chk_col_clear: assert property (s_col_rd ##1 s_col_rd |=> RDATA == 8'h00)
        else $error("collision low not cleared by read");
    chk_col_enable: assert property (!ENABLE ##1 (!ENABLE && HOST_REQ.rd
        && HOST_REQ.addr == ADDR_COL_LOW) |=> RDATA == 8'h00)
        else $error("collision low not zero with enable low");
    chk_str_msb: assert property (s_str_rd |=> !RDATA[7])
        else $error("strength unused bit set");
    chk_osc_early: assert property (s_str_rd ##0 (cnt + 2 < OSC_CYCLES)
        |=> !RDATA[6]) else $error("oscillator flag too early");
    chk_osc_late: assert property (s_str_rd ##0 (cnt > OSC_CYCLES + 2)
        |=> RDATA[6]) else $error("oscillator flag missing");
    chk_irq_cause: assert property ($rose(IRQ) |-> $past(cause)
        || $past(cause, 2)) else $error("request without source");
    chk_irq_release: assert property ((HOST_REQ.rd && !cause
        && HOST_REQ.addr == ADDR_IRQ_STATUS) ##1 !cause |=> !IRQ)
        else $error("request kept after status read");
    chk_irq_enable_low: assert property (!ENABLE ##1 !ENABLE |-> !IRQ)
        else $error("request with enable low");
endmodule
bind irq_col_rssi_regs irq_col_rssi_chk #(.OSC_CYCLES(OSC_CYCLES))
    i_irq_col_rssi_chk (.CLOCK, .RESET, .ENABLE, .HOST_REQ, .RX_EVT,
    .IRQ_SRC, .RDATA, .IRQ);

// *** test/irq_col_rssi_host.sv ***
`timescale 1ns/10ps
module irq_col_rssi_host (
    input wire logic CLOCK, // Device clock
    input wire logic [7:0] RDATA, // Read data from device
    output irq_col_rssi_pkg::host_req_s HOST_REQ // Host access
);
    import irq_col_rssi_pkg::*;
    initial HOST_REQ = '0;
    // Read data lands one edge after the request is driven
    task automatic acc(input logic w, input logic [4:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge CLOCK) HOST_REQ <= '{~w, w, a, d};
        @(posedge CLOCK) HOST_REQ <= '0;
        #1 q = RDATA;
    endtask
    // Holding rd over two edges makes two back-to-back reads
    task automatic rd_pair(input logic [4:0] a, output logic [7:0] q0, q1);
        @(posedge CLOCK) HOST_REQ <= '{1'b1, 1'b0, a, 8'h00};
        @(posedge CLOCK) #1 q0 = RDATA;
        @(posedge CLOCK) HOST_REQ <= '0;
        #1 q1 = RDATA;
    endtask
endmodule

// *** test/irq_col_rssi_regs_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module irq_col_rssi_regs_tb_top;
    import irq_col_rssi_pkg::*;
    logic clock = 0, reset = 1, enable = 1, swap = 0, six = 0, irq;
    host_req_s req;
    rx_event_s ev = '0;
    irq_src_s src = '0;
    logic [7:0] rdata, q, q1;
    int num_errors = 0, checks = 0;
    always #10 clock = ~clock;
    irq_col_rssi_regs #(.OSC_CYCLES(20)) i_irq_col_rssi_regs (.CLOCK(clock),
        .RESET(reset), .ENABLE(enable), .HOST_REQ(req), .RX_EVT(ev),
        .IRQ_SRC(src), .SWAP_INPUTS(swap), .COL_SIX_PULSES(six),
        .RDATA(rdata), .IRQ(irq));
    irq_col_rssi_host i_irq_col_rssi_host (.CLOCK(clock), .RDATA(rdata),
        .HOST_REQ(req));
    task automatic rd(input logic [4:0] a, input logic [7:0] e, string n);
        i_irq_col_rssi_host.acc(1'b0, a, 8'h00, q);
        `CHK(n, e, q)
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        i_irq_col_rssi_host.acc(1'b1, a, d, q);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input irq_src_s s);
        @(posedge clock) src <= s;
        @(posedge clock) src <= '0;
    endtask
    task automatic err(input logic [9:0] p);
        @(posedge clock) ev.err_valid <= 1'b1;
        ev.err_pos <= p;
        @(posedge clock) ev.err_valid <= 1'b0;
    endtask
    // Second cycle is weaker so only a held peak gives the first value
    task automatic meas(input logic [2:0] p, s);
        @(posedge clock) ev.rx_active <= 1'b1;
        ev.env_primary <= p;
        ev.env_secondary <= s;
        @(posedge clock) ev.env_primary <= 3'h1;
        ev.env_secondary <= 3'h1;
        @(posedge clock) ev.rx_active <= 1'b0;
    endtask
    task end_sim;
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rd(ADDR_IRQ_ENABLE, 8'h3e, "enable reset");
        rd(ADDR_COL_LOW, 8'h00, "col reset");
        rd(ADDR_STRENGTH, 8'h00, "osc early");
        rd(5'h10, 8'h00, "unmapped");
        wr(ADDR_IRQ_ENABLE, 8'hff);
        rd(ADDR_IRQ_ENABLE, 8'h3f, "enable write");
        err(10'h2a5);
        rd(ADDR_IRQ_ENABLE, 8'hbf, "col high");
        i_irq_col_rssi_host.rd_pair(ADDR_COL_LOW, q, q1);
        `CHK("col low", 8'ha5, q)
        `CHK("col cleared", 8'h00, q1)
        meas(3'h5, 3'h2);
        rd(ADDR_STRENGTH, 8'h55, "peak");
        @(posedge clock) ev.tx_start <= 1'b1;
        @(posedge clock) ev.tx_start <= 1'b0;
        rd(ADDR_STRENGTH, 8'h40, "tx clears");
        @(posedge clock) swap <= 1'b1;
        meas(3'h6, 3'h1);
        rd(ADDR_STRENGTH, 8'h71, "swapped");
        pulse(irq_src_s'(6'h10));
        tick(2);
        `CHK("irq set", 1'b1, irq)
        rd(ADDR_IRQ_STATUS, 8'h10, "status crc");
        tick(2);
        `CHK("irq released", 1'b0, irq)
        wr(ADDR_IRQ_ENABLE, 8'h00);
        pulse(irq_src_s'(6'h20));
        tick(2);
        `CHK("irq masked", 1'b0, irq)
        rd(ADDR_IRQ_STATUS, 8'h20, "masked flag");
        // Three bit boundaries after transmit, then seven pulses in bit 3
        @(posedge clock) ev.tx_start <= 1'b1;
        ev.type_a_106k <= 1'b1;
        ev.rx_active <= 1'b1;
        @(posedge clock) ev.tx_start <= 1'b0;
        ev.bit_boundary <= 1'b1;
        repeat (2) @(posedge clock);
        @(posedge clock) ev.bit_boundary <= 1'b0;
        ev.sub_pulse <= 1'b1;
        repeat (6) @(posedge clock);
        @(posedge clock) ev.sub_pulse <= 1'b0;
        ev.rx_active <= 1'b0;
        ev.type_a_106k <= 1'b0;
        rd(ADDR_COL_LOW, 8'h03, "collision pos");
        rd(ADDR_IRQ_STATUS, 8'h02, "collision flag");
        @(posedge clock) ev.amp_measure <= 1'b1;
        ev.rf_amplitude <= 3'h4;
        @(posedge clock) ev.amp_measure <= 1'b0;
        rd(ADDR_STRENGTH, 8'h64, "rf amplitude");
        err(10'h005);
        @(posedge clock) enable <= 1'b0;
        rd(ADDR_COL_LOW, 8'h00, "enable low");
        @(posedge clock) enable <= 1'b1;
        end_sim();
    end
endmodule
